// ### rtl/sdr_pkg.sv
// Shared constants and types of the step and direction output stage.
package sdr_pkg;

    // ====================================================================
    // Register offsets
    localparam logic [7:0] SDR_OFS_GLOBAL_CONFIG = 8'h00;
    localparam logic [7:0] SDR_OFS_STEP_DIR_TIMING = 8'h10;
    localparam logic [7:0] SDR_OFS_PROFILE_SELECT = 8'h20;
    localparam logic [7:0] SDR_OFS_CURRENT_POSITION = 8'h21;
    localparam logic [7:0] SDR_OFS_CURRENT_VELOCITY = 8'h22;
    localparam logic [7:0] SDR_OFS_CURRENT_ACCELERATION = 8'h23;
    localparam logic [7:0] SDR_OFS_VELOCITY_LIMIT = 8'h24;
    localparam logic [7:0] SDR_OFS_START_VELOCITY = 8'h25;
    localparam logic [7:0] SDR_OFS_STOP_VELOCITY = 8'h26;
    localparam logic [7:0] SDR_OFS_BREAKPOINT_VELOCITY = 8'h27;
    localparam logic [7:0] SDR_OFS_ACCELERATION_LIMIT = 8'h28;
    localparam logic [7:0] SDR_OFS_DECELERATION_LIMIT = 8'h29;
    localparam logic [7:0] SDR_OFS_INITIAL_ACCELERATION = 8'h2A;
    localparam logic [7:0] SDR_OFS_FINAL_DECELERATION = 8'h2B;
    localparam logic [7:0] SDR_OFS_JERK_VALUE_1 = 8'h2D;
    localparam logic [7:0] SDR_OFS_JERK_VALUE_4 = 8'h30;
    localparam logic [7:0] SDR_OFS_CLOCK_FREQUENCY_VALUE = 8'h31;
    localparam logic [7:0] SDR_OFS_TARGET_POSITION = 8'h37;

    // ====================================================================
    // Field positions
    localparam int unsigned SDR_GC_STEP_IDLE_POL_BIT = 3;
    localparam int unsigned SDR_GC_TOGGLE_STEP_BIT = 4;
    localparam int unsigned SDR_GC_DIR_POL_BIT = 5;
    localparam int unsigned SDR_GC_REVERSE_DIR_BIT = 28;
    localparam int unsigned SDR_TIM_WIDTH_LSB = 0;
    localparam int unsigned SDR_TIM_SETUP_LSB = 16;
    localparam int unsigned SDR_TIM_FIELD_W = 16;
    localparam int unsigned SDR_PROF_POS_MODE_BIT = 2;

    // ====================================================================
    // Register widths
    localparam int unsigned SDR_DATA_W = 32;
    localparam int unsigned SDR_PROF_W = 3;
    localparam int unsigned SDR_VEL_W = 24;
    localparam int unsigned SDR_ACC_W = 24;
    localparam int unsigned SDR_VSS_W = 31;
    localparam int unsigned SDR_ALIM_W = 24;
    localparam int unsigned SDR_JERK_W = 24;
    localparam int unsigned SDR_JERK_N = 4;
    localparam int unsigned SDR_CLKF_W = 25;

    // ====================================================================
    // Reset values
    localparam logic [31:0] SDR_GC_RESET = 32'h0000_0020;
    localparam logic [31:0] SDR_ZERO_RESET = 32'h0000_0000;

    // Step sequencer states, Gray coded along idle, pulse, hold.
    typedef enum logic [1:0] {
        SDR_IDLE = 2'b00,
        SDR_PULSE = 2'b01,
        SDR_HOLD = 2'b11,
        SDR_DIR_WAIT = 2'b10
    } sdr_state_t;

endpackage : sdr_pkg

// ### rtl/sdr_step_shaper.sv
// Step pin former: pulse or toggle encoding with selectable idle level.
`timescale 1ns/100ps
module sdr_step_shaper (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic pulse_phase_in,
    input wire logic idle_pol_in,
    input wire logic toggle_in,
    output logic step_pin_out
);
    logic phase_prev_reg;
    logic phase_prev_next;
    logic toggle_reg;
    logic toggle_next;
    logic pin_reg;
    logic pin_next;

    // ====================================================================
    // Next values; the toggle level flips on the first cycle of a pulse
    // phase so both encodings move the pin at the same edge. Outside toggle
    // mode the level is parked at zero, so entering toggle mode leaves the
    // pin at its idle level instead of making a stray step edge.
    always_comb begin
        phase_prev_next = pulse_phase_in;
        toggle_next = toggle_in ? toggle_reg ^ (pulse_phase_in & ~phase_prev_reg) : 1'b0;
        if (toggle_in) begin
            pin_next = toggle_next ^ idle_pol_in;
        end else begin
            pin_next = pulse_phase_in ^ idle_pol_in;
        end
    end

    // Registers only; the pin comes straight from a flip-flop.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_prev_reg <= 1'b0;
            toggle_reg <= 1'b0;
            pin_reg <= 1'b0;
        end else begin
            phase_prev_reg <= phase_prev_next;
            toggle_reg <= toggle_next;
            pin_reg <= pin_next;
        end
    end

    assign step_pin_out = pin_reg;

endmodule : sdr_step_shaper

// ### rtl/sdr_step_dir_out.sv
// Step and direction output stage with its ramp parameter registers.
`timescale 1ns/100ps
module sdr_step_dir_out #(
    parameter int unsigned MICROSTEP_W = 10
) (
    input wire logic MCLK_IN,
    input wire logic ARST_N_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [sdr_pkg::SDR_DATA_W-1:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [sdr_pkg::SDR_DATA_W-1:0] REG_RDATA_OUT,
    input wire logic STEP_REQ_IN,
    output logic STEP_READY_OUT,
    input wire logic [sdr_pkg::SDR_VEL_W-1:0] VELOCITY_IN,
    input wire logic [sdr_pkg::SDR_ACC_W-1:0] ACCEL_IN,
    output logic [sdr_pkg::SDR_PROF_W-1:0] PROFILE_SELECT_OUT,
    output logic POSITIONING_MODE_OUT,
    output logic [sdr_pkg::SDR_DATA_W-1:0] TARGET_POSITION_OUT,
    output logic [MICROSTEP_W-1:0] MICROSTEP_COUNT_OUT,
    output logic STEP_OUTPUT_PIN_OUT,
    output logic DIRECTION_OUTPUT_PIN_OUT
);
    import sdr_pkg::*;

    // Counter widths outside this range cannot be served by the walk logic.
    if (MICROSTEP_W < 2 || MICROSTEP_W > 16) begin : g_bad_width
        $error("MICROSTEP_W must lie between 2 and 16.");
    end

    // Direction pin level for a microstep walk; the polarity bit set means
    // a backward walk shows as a high pin.
    function automatic logic dir_level(input logic fwd, input logic pol);
        dir_level = pol ? ~fwd : fwd;
    endfunction : dir_level

    // ====================================================================
    // Register storage
    logic [31:0] gc_reg, gc_next;
    logic [31:0] timing_reg, timing_next;
    logic [SDR_PROF_W-1:0] prof_reg, prof_next;
    logic [31:0] pos_reg, pos_next;
    logic [SDR_VEL_W-1:0] vel_reg, vel_next;
    logic [SDR_ACC_W-1:0] acc_reg, acc_next;
    logic [31:0] vlim_reg, vlim_next;
    logic [SDR_VSS_W-1:0] start_velocity_reg, start_velocity_next;
    logic [SDR_VSS_W-1:0] stop_velocity_reg, stop_velocity_next;
    logic [SDR_VSS_W-1:0] breakpoint_velocity_reg, breakpoint_velocity_next;
    logic [SDR_ALIM_W-1:0] acceleration_limit_reg, acceleration_limit_next;
    logic [SDR_ALIM_W-1:0] deceleration_limit_reg, deceleration_limit_next;
    logic [SDR_ALIM_W-1:0] initial_acceleration_reg, initial_acceleration_next;
    logic [SDR_ALIM_W-1:0] final_deceleration_reg, final_deceleration_next;
    logic [SDR_JERK_W-1:0] jerk_reg [SDR_JERK_N];
    logic [SDR_JERK_W-1:0] jerk_next [SDR_JERK_N];
    logic [SDR_CLKF_W-1:0] clkf_reg, clkf_next;
    logic [31:0] xtgt_reg, xtgt_next;
    logic [31:0] rdata_reg, rdata_next;

    // Step sequencer state
    sdr_state_t state_reg, state_next;
    logic [SDR_TIM_FIELD_W-1:0] cnt_reg, cnt_next;
    logic dir_reg, dir_next;
    logic [MICROSTEP_W-1:0] microstep_counter_reg, microstep_counter_next;

    // Configuration fields
    logic [SDR_TIM_FIELD_W-1:0] step_width;
    logic [SDR_TIM_FIELD_W-1:0] dir_setup;
    logic idle_pol;
    logic toggle_mode;
    logic dir_pol;
    logic reverse_dir;
    logic req_neg;
    logic req_fwd;
    logic req_dir;
    logic step_take;
    logic [7:0] jerk_idx;

    assign step_width = timing_reg[SDR_TIM_WIDTH_LSB +: SDR_TIM_FIELD_W];
    assign dir_setup = timing_reg[SDR_TIM_SETUP_LSB +: SDR_TIM_FIELD_W];
    assign idle_pol = gc_reg[SDR_GC_STEP_IDLE_POL_BIT];
    assign toggle_mode = gc_reg[SDR_GC_TOGGLE_STEP_BIT];
    assign dir_pol = gc_reg[SDR_GC_DIR_POL_BIT];
    assign reverse_dir = gc_reg[SDR_GC_REVERSE_DIR_BIT];

    // The request's walk comes from the velocity sign and the reverse bit,
    // and the pin level is taken from that walk.
    assign req_neg = VELOCITY_IN[SDR_VEL_W-1];
    assign req_fwd = ~req_neg ^ reverse_dir;
    assign req_dir = dir_level(req_fwd, dir_pol);
    assign STEP_READY_OUT = (state_reg == SDR_IDLE) && (req_dir == dir_reg);
    assign step_take = STEP_REQ_IN && STEP_READY_OUT;
    assign jerk_idx = REG_ADDR_IN - SDR_OFS_JERK_VALUE_1;

    // ====================================================================
    // Register writes. A software write to the position wins over a step
    // landing in the same cycle, so an overwrite is never half applied.
    always_comb begin
        gc_next = gc_reg;
        timing_next = timing_reg;
        prof_next = prof_reg;
        vlim_next = vlim_reg;
        start_velocity_next = start_velocity_reg;
        stop_velocity_next = stop_velocity_reg;
        breakpoint_velocity_next = breakpoint_velocity_reg;
        acceleration_limit_next = acceleration_limit_reg;
        deceleration_limit_next = deceleration_limit_reg;
        initial_acceleration_next = initial_acceleration_reg;
        final_deceleration_next = final_deceleration_reg;
        jerk_next = jerk_reg;
        clkf_next = clkf_reg;
        xtgt_next = xtgt_reg;
        vel_next = VELOCITY_IN;
        acc_next = ACCEL_IN;
        pos_next = pos_reg;
        if (step_take) begin
            pos_next = req_neg ? pos_reg - 32'h0000_0001 : pos_reg + 32'h0000_0001;
        end
        if (REG_WR_IN) begin
            case (REG_ADDR_IN)
                SDR_OFS_GLOBAL_CONFIG: gc_next = REG_WDATA_IN;
                SDR_OFS_STEP_DIR_TIMING: timing_next = REG_WDATA_IN;
                SDR_OFS_PROFILE_SELECT: prof_next = REG_WDATA_IN[SDR_PROF_W-1:0];
                SDR_OFS_CURRENT_POSITION: pos_next = REG_WDATA_IN;
                SDR_OFS_VELOCITY_LIMIT: vlim_next = REG_WDATA_IN;
                SDR_OFS_START_VELOCITY: start_velocity_next = REG_WDATA_IN[SDR_VSS_W-1:0];
                SDR_OFS_STOP_VELOCITY: stop_velocity_next = REG_WDATA_IN[SDR_VSS_W-1:0];
                SDR_OFS_BREAKPOINT_VELOCITY: breakpoint_velocity_next = REG_WDATA_IN[SDR_VSS_W-1:0];
                SDR_OFS_ACCELERATION_LIMIT: acceleration_limit_next = REG_WDATA_IN[SDR_ALIM_W-1:0];
                SDR_OFS_DECELERATION_LIMIT: deceleration_limit_next = REG_WDATA_IN[SDR_ALIM_W-1:0];
                SDR_OFS_INITIAL_ACCELERATION: initial_acceleration_next = REG_WDATA_IN[SDR_ALIM_W-1:0];
                SDR_OFS_FINAL_DECELERATION: final_deceleration_next = REG_WDATA_IN[SDR_ALIM_W-1:0];
                SDR_OFS_CLOCK_FREQUENCY_VALUE: clkf_next = REG_WDATA_IN[SDR_CLKF_W-1:0];
                SDR_OFS_TARGET_POSITION: xtgt_next = REG_WDATA_IN;
                default: begin
                    if (REG_ADDR_IN >= SDR_OFS_JERK_VALUE_1 && REG_ADDR_IN <= SDR_OFS_JERK_VALUE_4) begin
                        jerk_next[jerk_idx[1:0]] = REG_WDATA_IN[SDR_JERK_W-1:0];
                    end
                end
            endcase
        end
    end

    // ====================================================================
    // Read data is captured on the read strobe; unmapped offsets read zero
    // and narrow registers read zero above their width.
    always_comb begin
        rdata_next = rdata_reg;
        if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                SDR_OFS_GLOBAL_CONFIG: rdata_next = gc_reg;
                SDR_OFS_STEP_DIR_TIMING: rdata_next = timing_reg;
                SDR_OFS_PROFILE_SELECT: rdata_next = 32'(prof_reg);
                SDR_OFS_CURRENT_POSITION: rdata_next = pos_reg;
                SDR_OFS_CURRENT_VELOCITY: rdata_next = 32'(vel_reg);
                SDR_OFS_CURRENT_ACCELERATION: rdata_next = 32'(acc_reg);
                SDR_OFS_VELOCITY_LIMIT: rdata_next = vlim_reg;
                SDR_OFS_START_VELOCITY: rdata_next = 32'(start_velocity_reg);
                SDR_OFS_STOP_VELOCITY: rdata_next = 32'(stop_velocity_reg);
                SDR_OFS_BREAKPOINT_VELOCITY: rdata_next = 32'(breakpoint_velocity_reg);
                SDR_OFS_ACCELERATION_LIMIT: rdata_next = 32'(acceleration_limit_reg);
                SDR_OFS_DECELERATION_LIMIT: rdata_next = 32'(deceleration_limit_reg);
                SDR_OFS_INITIAL_ACCELERATION: rdata_next = 32'(initial_acceleration_reg);
                SDR_OFS_FINAL_DECELERATION: rdata_next = 32'(final_deceleration_reg);
                SDR_OFS_CLOCK_FREQUENCY_VALUE: rdata_next = 32'(clkf_reg);
                SDR_OFS_TARGET_POSITION: rdata_next = xtgt_reg;
                default: begin
                    rdata_next = SDR_ZERO_RESET;
                    if (REG_ADDR_IN >= SDR_OFS_JERK_VALUE_1 && REG_ADDR_IN <= SDR_OFS_JERK_VALUE_4) begin
                        rdata_next = 32'(jerk_reg[jerk_idx[1:0]]);
                    end
                end
            endcase
        end
    end

    // ====================================================================
    // Step sequencer. A direction change is made only from idle, which the
    // hold phase guarantees is width+1 cycles after the pulse ends; the
    // setup wait then blocks steps. The hold phase also spaces steps of the
    // same direction, trading peak step rate for a simple timing proof.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        microstep_counter_next = microstep_counter_reg;
        case (state_reg)
            SDR_IDLE: begin
                if (step_take) begin
                    state_next = SDR_PULSE;
                    cnt_next = step_width;
                    microstep_counter_next = req_fwd ? microstep_counter_reg + 1'b1 : microstep_counter_reg - 1'b1;
                end else if (STEP_REQ_IN) begin
                    state_next = SDR_DIR_WAIT;
                    dir_next = req_dir;
                    cnt_next = dir_setup;
                end
            end
            SDR_PULSE: begin
                if (cnt_reg == '0) begin
                    state_next = SDR_HOLD;
                    cnt_next = step_width;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            SDR_HOLD, SDR_DIR_WAIT: begin
                if (cnt_reg == '0) begin
                    state_next = SDR_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                state_next = SDR_IDLE;
            end
        endcase
    end

    // All register groups are only registered here.
    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            gc_reg <= SDR_GC_RESET;
            timing_reg <= SDR_ZERO_RESET;
            prof_reg <= '0;
            pos_reg <= SDR_ZERO_RESET;
            vel_reg <= '0;
            acc_reg <= '0;
            vlim_reg <= SDR_ZERO_RESET;
            start_velocity_reg <= '0;
            stop_velocity_reg <= '0;
            breakpoint_velocity_reg <= '0;
            acceleration_limit_reg <= '0;
            deceleration_limit_reg <= '0;
            initial_acceleration_reg <= '0;
            final_deceleration_reg <= '0;
            for (int i = 0; i < SDR_JERK_N; i++) begin
                jerk_reg[i] <= '0;
            end
            clkf_reg <= '0;
            xtgt_reg <= SDR_ZERO_RESET;
            rdata_reg <= SDR_ZERO_RESET;
            state_reg <= SDR_IDLE;
            cnt_reg <= '0;
            dir_reg <= 1'b0;
            microstep_counter_reg <= '0;
        end else begin
            gc_reg <= gc_next;
            timing_reg <= timing_next;
            prof_reg <= prof_next;
            pos_reg <= pos_next;
            vel_reg <= vel_next;
            acc_reg <= acc_next;
            vlim_reg <= vlim_next;
            start_velocity_reg <= start_velocity_next;
            stop_velocity_reg <= stop_velocity_next;
            breakpoint_velocity_reg <= breakpoint_velocity_next;
            acceleration_limit_reg <= acceleration_limit_next;
            deceleration_limit_reg <= deceleration_limit_next;
            initial_acceleration_reg <= initial_acceleration_next;
            final_deceleration_reg <= final_deceleration_next;
            jerk_reg <= jerk_next;
            clkf_reg <= clkf_next;
            xtgt_reg <= xtgt_next;
            rdata_reg <= rdata_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            dir_reg <= dir_next;
            microstep_counter_reg <= microstep_counter_next;
        end
    end

    // ====================================================================
    // Step pin former and output wiring.
    sdr_step_shaper u_shaper (
        .clk_in(MCLK_IN),
        .rst_n_in(ARST_N_IN),
        .pulse_phase_in(state_reg == SDR_PULSE),
        .idle_pol_in(idle_pol),
        .toggle_in(toggle_mode),
        .step_pin_out(STEP_OUTPUT_PIN_OUT)
    );

    assign DIRECTION_OUTPUT_PIN_OUT = dir_reg;
    assign REG_RDATA_OUT = rdata_reg;
    assign PROFILE_SELECT_OUT = prof_reg;
    assign POSITIONING_MODE_OUT = prof_reg[SDR_PROF_POS_MODE_BIT];
    assign TARGET_POSITION_OUT = xtgt_reg;
    assign MICROSTEP_COUNT_OUT = microstep_counter_reg;

    // ====================================================================
    // Checking helpers: pulse phase as seen on the pin, its length, and the
    // cycles since the last pulse and the last direction change.
    logic act_q;
    logic [16:0] width_cnt_q;
    logic [16:0] since_fall_q;
    logic [16:0] since_dir_q;

    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            act_q <= 1'b0;
            width_cnt_q <= '0;
            since_fall_q <= 17'h1FFFF;
            since_dir_q <= 17'h1FFFF;
        end else begin
            act_q <= (state_reg == SDR_PULSE);
            width_cnt_q <= act_q ? width_cnt_q + 1'b1 : '0;
            since_fall_q <= act_q ? '0 : (&since_fall_q ? since_fall_q : since_fall_q + 1'b1);
            since_dir_q <= (dir_next != dir_reg) ? '0
                : (&since_dir_q ? since_dir_q : since_dir_q + 1'b1);
        end
    end

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!ARST_N_IN);

    sequence s_take_plain;
        step_take && !toggle_mode && !REG_WR_IN;
    endsequence

    sequence s_pin_active;
        ##1 (state_reg == SDR_PULSE) ##1 (STEP_OUTPUT_PIN_OUT == ~idle_pol);
    endsequence

    property p_pulse_width;
        $fell(act_q) && $stable(timing_reg) |-> width_cnt_q == 17'(step_width) + 17'h1;
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("Step pulse width wrong.");

    property p_dir_setup;
        step_take |-> since_dir_q >= 17'(dir_setup);
    endproperty
    a_dir_setup: assert property (p_dir_setup) else $error("Step inside direction setup.");

    property p_dir_stable_pulse;
        act_q |-> $stable(DIRECTION_OUTPUT_PIN_OUT);
    endproperty
    a_dir_stable_pulse: assert property (p_dir_stable_pulse) else $error("Direction moved in pulse.");

    property p_dir_hold;
        (dir_next != dir_reg) |-> since_fall_q >= 17'(step_width);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("Direction moved in hold time.");

    property p_rise_marks_step;
        s_take_plain |-> s_pin_active;
    endproperty
    a_rise_marks_step: assert property (p_rise_marks_step) else $error("Step level wrong.");

    property p_toggle_step;
        step_take && toggle_mode && !REG_WR_IN |-> ##2 $changed(STEP_OUTPUT_PIN_OUT);
    endproperty
    a_toggle_step: assert property (p_toggle_step) else $error("Toggle step missing.");

    property p_dir_level;
        step_take |=> DIRECTION_OUTPUT_PIN_OUT
            == ($past(dir_pol) ^ (MICROSTEP_COUNT_OUT == $past(microstep_counter_reg) + 1'b1));
    endproperty
    a_dir_level: assert property (p_dir_level) else $error("Direction level wrong.");

    property p_microstep_walk;
        step_take |=> MICROSTEP_COUNT_OUT == (($past(VELOCITY_IN[SDR_VEL_W-1]) ^ $past(reverse_dir))
            ? $past(microstep_counter_reg) - 1'b1 : $past(microstep_counter_reg) + 1'b1);
    endproperty
    a_microstep_walk: assert property (p_microstep_walk) else $error("Microstep walk wrong.");

    property p_pos_write;
        REG_WR_IN && REG_ADDR_IN == SDR_OFS_CURRENT_POSITION |=> pos_reg == $past(REG_WDATA_IN);
    endproperty
    a_pos_write: assert property (p_pos_write) else $error("Position write lost.");

    property p_one_step_per_advance;
        $changed(microstep_counter_reg) |-> ##1 act_q;
    endproperty
    a_one_step_per_advance: assert property (p_one_step_per_advance) else $error("Step missing.");

endmodule : sdr_step_dir_out

// ### tb/sdr_drv_model.sv
// Behavioural stepper driver that counts step events and measures pin timing.
`timescale 1ns/100ps
module sdr_drv_model (
    input wire logic clk_in,
    input wire logic step_pin_in,
    input wire logic dir_pin_in,
    input wire logic idle_pol_in,
    input wire logic toggle_in,
    input wire logic dir_pol_in,
    output int fwd_cnt_out,
    output int back_cnt_out,
    output int width_out,
    output int setup_out,
    output int hold_out
);
    logic step_q = 1'b0;
    logic dir_q = 1'b0;
    int run = 0;
    int since_dir = 0;
    int since_fall = 0;
    // ====================================================================
    // Pin sampler
    // Pins are sampled on the system clock, so every figure is in whole cycles.
    always @(posedge clk_in) begin
        if (step_pin_in !== step_q && (toggle_in || step_pin_in !== idle_pol_in)) begin
            if (dir_pol_in ? dir_pin_in : !dir_pin_in) begin
                back_cnt_out++;
            end else begin
                fwd_cnt_out++;
            end
            setup_out = since_dir;
        end
        if (!toggle_in && step_pin_in === idle_pol_in && run > 0) begin
            width_out = run;
        end
        run = (!toggle_in && step_pin_in !== idle_pol_in) ? run + 1 : 0;
        since_fall = (step_pin_in === step_q) ? since_fall + 1 : 1;
        if (dir_pin_in !== dir_q) begin
            hold_out = since_fall;
            since_dir = 1;
        end else begin
            since_dir++;
        end
        step_q = step_pin_in;
        dir_q = dir_pin_in;
    end
endmodule : sdr_drv_model

// ### tb/sdr_step_dir_out_tb.sv
// Self-checking bench of the step and direction output stage.
`timescale 1ns/100ps
module sdr_step_dir_out_tb;
    import sdr_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} sdr_row_t;
    logic clk, rst_n, wr, rd, req, ready, stp, dir, pm, ipol, tog, dpol;
    logic [7:0] addr;
    logic [31:0] wd, rdat, tgt;
    logic [23:0] vel, acc;
    logic [2:0] prof;
    logic [9:0] ms;
    int fwd, back, wid, stu, hld, error_cnt, cmp_count;
    // Each row is written, then read back: address, write data, read value.
    sdr_row_t rows[20] = '{
        '{8'h20, 32'hFFFF_FFFF, 32'h7}, '{8'h21, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
        '{8'h22, 32'hFFFF_FFFF, 32'h5}, '{8'h23, 32'h0, 32'hFF_FFFE},
        '{8'h24, 32'h8000_0001, 32'h8000_0001}, '{8'h25, 32'hFFFF_FFFF, 32'h7FFF_FFFF},
        '{8'h27, 32'hFFFF_FFFF, 32'h7FFF_FFFF}, '{8'h29, 32'hFFFF_FFFF, 32'hFF_FFFF},
        '{8'h2A, 32'hFFFF_FFFF, 32'hFF_FFFF}, '{8'h2D, 32'hFFFF_FFFF, 32'hFF_FFFF},
        '{8'h30, 32'hFFFF_FFFF, 32'hFF_FFFF}, '{8'h37, 32'h8000_0001, 32'h8000_0001},
        '{8'h26, 32'hFFFF_FFFF, 32'h7FFF_FFFF}, '{8'h28, 32'hFFFF_FFFF, 32'hFF_FFFF},
        '{8'h2B, 32'hFFFF_FFFF, 32'hFF_FFFF}, '{8'h2E, 32'h0012_3456, 32'h12_3456},
        '{8'h2F, 32'hAB65_4321, 32'h65_4321}, '{8'h31, 32'hFFFF_FFFF, 32'h1FF_FFFF},
        '{8'h2C, 32'hFFFF_FFFF, 32'h0}, '{8'h10, 32'h0005_0003, 32'h0005_0003}};
    sdr_step_dir_out dut (.MCLK_IN(clk), .ARST_N_IN(rst_n), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdat),
        .STEP_REQ_IN(req), .STEP_READY_OUT(ready), .VELOCITY_IN(vel), .ACCEL_IN(acc),
        .PROFILE_SELECT_OUT(prof), .POSITIONING_MODE_OUT(pm), .TARGET_POSITION_OUT(tgt),
        .MICROSTEP_COUNT_OUT(ms), .STEP_OUTPUT_PIN_OUT(stp), .DIRECTION_OUTPUT_PIN_OUT(dir));
    sdr_drv_model drv (.clk_in(clk), .step_pin_in(stp), .dir_pin_in(dir), .idle_pol_in(ipol),
        .toggle_in(tog), .dir_pol_in(dpol), .fwd_cnt_out(fwd), .back_cnt_out(back),
        .width_out(wid), .setup_out(stu), .hold_out(hld));
    // ====================================================================
    // Clock and shared tasks
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task stop_test;
        if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    // One strobe cycle; a read leaves its data settled just after the edge.
    task acc_reg(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk) #1;
        addr = a;
        wd = d;
        wr = w;
        rd = !w;
        @(posedge clk) #1;
        wr = 1'b0;
        rd = 1'b0;
    endtask : acc_reg
    // The request is held until ready is seen, so a direction wait loses nothing.
    task step;
        int n;
        @(posedge clk) #1;
        req = 1'b1;
        n = 0;
        while (ready !== 1'b1 && n < 200) begin
            @(posedge clk) #1;
            n++;
        end
        @(posedge clk) #1;
        req = 1'b0;
        check({31'h0, ready}, 32'h0);
        repeat (12) @(posedge clk);
        #1;
    endtask : step
    // ====================================================================
    // Watchdog and main sequence
    initial begin
        #75000;
        error_cnt++;
        $display("Error %0t: timeout", $time);
        stop_test();
    end
    initial begin
        {rst_n, wr, rd, req, addr, wd, ipol, tog, dpol} = '0;
        vel = 24'h00_0005;
        acc = 24'hFF_FFFE;
        dpol = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        check({30'h0, stp, dir}, 32'h0);
        acc_reg(8'h00, 1'b0, 32'h0);
        check(rdat, 32'h20);
        foreach (rows[i]) begin
            acc_reg(rows[i].a, 1'b1, rows[i].d);
            acc_reg(rows[i].a, 1'b0, 32'h0);
            check(rdat, rows[i].e);
        end
        check({28'h0, pm, prof}, 32'hF);
        check(tgt, 32'h8000_0001);
        step();
        check(fwd, 1);
        check(wid, 4);
        vel = 24'hFF_FFFF;
        step();
        check({22'h0, ms}, 32'h0);
        check(back, 1);
        check(stu > 5, 1);
        check(hld > 4, 1);
        acc_reg(8'h00, 1'b1, 32'h28);
        ipol = 1'b1;
        vel = 24'h00_0005;
        step();
        check(fwd, 2);
        check(wid, 4);
        acc_reg(8'h00, 1'b1, 32'h1000_0018);
        dpol = 1'b0;
        tog = 1'b1;
        repeat (3) step();
        check(back, 4);
        check({22'h0, ms}, 32'h3FE);
        acc_reg(8'h21, 1'b0, 32'h0);
        check(rdat, 32'h3);
        // A second reset in mid-run must bring back idle pins and defaults.
        rst_n = 1'b0;
        {ipol, tog, dpol} = 3'b001;
        @(posedge clk) #1;
        rst_n = 1'b1;
        check({30'h0, stp, dir}, 32'h0);
        check({31'h0, ready}, 32'h1);
        check({28'h0, pm, prof}, 32'h0);
        check(tgt, 32'h0);
        acc_reg(8'h21, 1'b0, 32'h0);
        check(rdat, 32'h0);
        step();
        check(fwd, 3);
        check(wid, 1);
        stop_test();
    end
endmodule : sdr_step_dir_out_tb
